/* tb/supply_supervisor_mode_control_tb.sv */
/*
  self-checking bench for the supply supervisor mode control block.
  assumes the design package, a 40 MHz clock and a shortened long-settle count.
*/
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
  samplesChecked++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module supply_supervisor_mode_control_tb
  import supply_supervisor_pkg::*;
;
  localparam int SLOW = 200;                   // short long-settle, keeps run brief
  logic              core_clk = 1'b0;          // core clock
  logic              rst_b    = 1'b0;          // active low reset
  regReq_t           regReq   = '0;            // register request
  logic [DATA_W-1:0] regRdata;                 // read data
  powerMode_t        powerMode = PM_ACTIVE;    // mode from the core
  logic              wakeIrq  = 1'b0;          // wake interrupt
  logic [1:0]        coreLevel = 2'h0;         // core level
  logic [1:0]        rec      = 2'h0;          // b0 external recover, b1 clear
  logic [3:0]        ev       = 4'h0;          // low sup, high sup, low mon, high mon
  logic              wakeGrant, cpuHold, oscOvershoot, wakeStuck, porRequest;
  supState_t         lowSupState, lowMonState, highSupState, highMonState;
  int                errors = 0;               // mismatch count
  int                samplesChecked = 0;       // comparison count
  int                seed = 32'h6AE1F51A;      // fixed random seed
  logic [31:0]       expQ[$];                  // read notes: mask and value
  logic              rdSeen_ff = 1'b0;         // read launched last cycle
  logic [31:0]       note;                     // note being compared
  logic [6:0]        lowCtl, highCtl;          // random control words

  supply_supervisor_mode_control #(.SLOW_CYCLES(SLOW)) u_supply_supervisor_mode_control (
    .core_clk(core_clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
    .powerMode(powerMode), .wakeIrq(wakeIrq), .wakeGrant(wakeGrant), .cpuHold(cpuHold),
    .oscOvershoot(oscOvershoot), .wakeStuck(wakeStuck), .coreLevel(coreLevel),
    .powerUpClear(rec[1]), .extRecover(rec[0]), .lowSupEvent(ev[0]), .highSupEvent(ev[1]),
    .lowMonEvent(ev[2]), .highMonEvent(ev[3]), .lowSupState(lowSupState),
    .lowMonState(lowMonState), .highSupState(highSupState), .highMonState(highMonState),
    .porRequest(porRequest));

  // free-running clock, 25 ns period
  always #12.5 core_clk = ~core_clk;

  // read data stand one cycle only, so compare in that cycle against the oldest note
  always @(posedge core_clk) begin
    if (rdSeen_ff) begin
      note = expQ.pop_front();
      `CHECK(regRdata & note[31:16], note[15:0])
    end
    rdSeen_ff <= regReq.rd;
  end

  // expected supervisor state, worked out from the control bits
  function automatic supState_t sup(logic [6:0] c, logic d);
    if (!c[SUP_EN_BIT] || (d && !c[SUP_KEEP_BIT])) return SUP_OFF;
    if (d && c[AUTO_BIT]) return c[SUP_FP_BIT] ? SUP_NORMAL : SUP_OFF;
    return c[SUP_FP_BIT] ? SUP_FULL : SUP_NORMAL;
  endfunction

  // expected monitor state: no keep bit, auto drops one step
  function automatic supState_t mon(logic [6:0] c, logic d);
    if (!c[MON_EN_BIT]) return SUP_OFF;
    if (d && c[AUTO_BIT]) return c[MON_FP_BIT] ? SUP_NORMAL : SUP_OFF;
    return c[MON_FP_BIT] ? SUP_FULL : SUP_NORMAL;
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one-cycle write strobe
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq <= '0;
  endtask

  // one-cycle read strobe, expectation noted for the monitor
  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e, logic [15:0] m = 16'hFFFF);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    expQ.push_back({m, e & m});
    @(posedge core_clk);
    regReq <= '0;
  endtask

  // one-cycle event and recovery pulses
  task automatic pulse(logic [3:0] e, logic [1:0] r);
    ev <= e;
    rec <= r;
    @(posedge core_clk);
    ev <= 4'h0;
    rec <= 2'h0;
  endtask

  // deep three entry with the entry window long closed, then count hold cycles
  task automatic wakeRun(int expHold);
    int hold = 0;
    int osc = 0;
    // no divider or subsystem users here to prepare
    powerMode <= PM_THREE;
    tick(50);
    wakeIrq <= 1'b1;
    #1;
    `CHECK(wakeGrant, 1'b1)
    @(posedge core_clk);
    wakeIrq <= 1'b0;
    powerMode <= PM_ACTIVE;
    // nothing driven until level waits and overshoot pass
    for (int k = 0; k < 400; k++) begin
      #1;
      hold += cpuHold;
      osc += oscOvershoot;
      @(posedge core_clk);
    end
    `CHECK(hold, expHold)
    `CHECK(osc, OVERSHOOT_CYCLES)
  endtask

  task automatic endTest(string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog, well beyond the expected run of some 3900 cycles
  initial begin
    #(20000 * 25);
    errors++;
    finish_test;
  end

  initial begin
    tick(8);
    rst_b <= 1'b1;
    // reset values and an unmapped address
    rd(LOW_CTL_ADDR, {9'h000, CTL_RESET});
    rd(HIGH_CTL_ADDR, {9'h000, CTL_RESET});
    rd(FLAG_ADDR, {10'h000, FLAG_RESET});
    rd(STAT_ADDR, 16'h0055);
    rd(4'h2, 16'h0000);
    endTest("reset");
    // random control words, active and deep states
    for (int i = 0; i < 6; i++) begin
      lowCtl = 7'($random(seed));
      highCtl = 7'($random(seed));
      wr(LOW_CTL_ADDR, {9'h000, lowCtl});
      wr(HIGH_CTL_ADDR, {9'h000, highCtl});
      tick(SLOW + 10);
      rd(STAT_ADDR, {8'h00, mon(highCtl, 0), sup(highCtl, 0),
                     mon(lowCtl, 0), sup(lowCtl, 0)});
      powerMode <= i[0] ? PM_FOUR : PM_TWO;
      tick(3);
      #1;
      `CHECK(lowSupState, sup(lowCtl, 1))
      `CHECK(lowMonState, mon(lowCtl, 1))
      `CHECK(highSupState, sup(highCtl, 1))
      `CHECK(highMonState, mon(highCtl, 1))
      @(posedge core_clk);
      powerMode <= PM_ACTIVE;
    end
    endTest("mapping");
    // fast then slow settle of the low side delay flag
    for (int f = 1; f >= 0; f--) begin
      wr(LOW_CTL_ADDR, f ? 16'h0055 : 16'h004B);
      tick((f ? FAST_CYCLES : SLOW) - 10);
      rd(FLAG_ADDR, 16'h0000, 16'h0001);
      tick(15);
      rd(FLAG_ADDR, 16'h0001, 16'h0001);
    end
    wr(FLAG_ADDR, 16'h003E);
    rd(FLAG_ADDR, 16'h0000, 16'h0001);
    endTest("settle");
    // slow mask for normal low side, short mask for full performance
    wr(HIGH_CTL_ADDR, 16'h004B);
    for (int f = 0; f < 2; f++) begin
      if (f) wr(LOW_CTL_ADDR, 16'h0055);
      tick(SLOW + 10);
      wakeRun(f ? FAST_CYCLES : SLOW);
    end
    endTest("wake");
    // affected setup, interrupt inside the entry window, two recoveries
    wr(HIGH_CTL_ADDR, 16'h0001);
    tick(SLOW + 10);
    for (int r = 0; r < 2; r++) begin
      // entry is seen first, so the window counter is loaded when the interrupt comes
      powerMode <= PM_TWO;
      @(posedge core_clk);
      wakeIrq <= 1'b1;
      #1;
      `CHECK(wakeGrant, 1'b0)
      @(posedge core_clk);
      #1;
      `CHECK(wakeStuck, 1'b1)
      @(posedge core_clk);
      wakeIrq <= 1'b0;
      powerMode <= PM_ACTIVE;
      pulse(4'h0, 2'(2'h1 << r));
      #1;
      `CHECK(wakeStuck, 1'b0)
      tick(5);
    end
    endTest("lost wake");
    // each event sets its flag, only the low supervisor has reset enabled
    for (int e = 0; e < 4; e++) begin
      pulse(4'(4'h1 << e), 2'h0);
      #1;
      `CHECK(porRequest, 1'(e == 0))
      @(posedge core_clk);
    end
    rd(FLAG_ADDR, 16'h003C, 16'h003C);
    wr(FLAG_ADDR, 16'h0000);
    rd(FLAG_ADDR, 16'h0000, 16'h003C);
    endTest("events");
    // core raise resets in full performance but not in normal
    coreLevel <= 2'h1;
    @(posedge core_clk);
    #1;
    `CHECK(porRequest, 1'b1)
    wr(LOW_CTL_ADDR, 16'h004B);
    tick(SLOW + 10);
    coreLevel <= 2'h2;
    @(posedge core_clk);
    #1;
    `CHECK(porRequest, 1'b0)
    endTest("core raise");
    // clear while disabled kills flags until the next control write
    wr(LOW_CTL_ADDR, 16'h0000);
    tick(SLOW + 10);
    pulse(4'h0, 2'h2);
    // both low supervisor and monitor events must be swallowed
    pulse(4'h5, 2'h0);
    rd(FLAG_ADDR, 16'h0000, 16'h0014);
    wr(LOW_CTL_ADDR, 16'h004B);
    tick(SLOW + 10);
    pulse(4'h4, 2'h0);
    rd(FLAG_ADDR, 16'h0010, 16'h0010);
    endTest("dead flags");
    tick(3);
    finish_test;
  end
endmodule

/* verilog/supply_supervisor_mode_control.sv */
/*
  supply supervisor mode control: low and high side supervisor and monitor
  state selection, settling delays and flags, wake-up execution mask,
  oscillator overshoot window, lost-wake detection and reset requests.
  assumes synchronous inputs on core_clk and a one-cycle strobe register port.
*/
// Implementation choices: the address map and strobed register access.
// Functional notes
// - flags dead after clear if supervisor off
// - normal low side masks wake for 150us
// - off or full-perf low side masks 2us
// - oscillator overshoot up to 6us after wake
// - subsystem clock overshoot is never masked
// - full-perf low side settles in 2us
// - core raise in full-perf causes reset
// - normal low side settles in 150us
// - early interrupt in affected setup loses wake
// - stuck wake recovers on reset or clear
// - low supervisor state from enable, keep, perf
// - keep and auto bits pick deep state
// - monitor state follows perf and auto bits
// - high supervisor maps like low supervisor
// - delay flag set when settled, zero clears
// - supervisor event flags and may request reset
`timescale 1ns/1ps
module supply_supervisor_mode_control
  import supply_supervisor_pkg::*;
#(
  parameter int SLOW_CYCLES = SLOW_DELAY_US * CLK_MHZ  // long settle and mask
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // register port
  input  wire regReq_t           regReq,
  output logic [DATA_W-1:0]      regRdata,
  // power mode and wake
  input  wire powerMode_t        powerMode,
  input  wire logic              wakeIrq,
  output logic                   wakeGrant,
  output logic                   cpuHold,
  output logic                   oscOvershoot,
  output logic                   wakeStuck,
  // core level and recovery
  input  wire logic [1:0]        coreLevel,
  input  wire logic              powerUpClear,
  input  wire logic              extRecover,
  // comparator events
  input  wire logic              lowSupEvent,
  input  wire logic              highSupEvent,
  input  wire logic              lowMonEvent,
  input  wire logic              highMonEvent,
  // selected states and reset request
  output supState_t              lowSupState,
  output supState_t              lowMonState,
  output supState_t              highSupState,
  output supState_t              highMonState,
  output logic                   porRequest
);

  // counter width covers the longest load
  localparam int CW = $clog2(SLOW_CYCLES + OVERSHOOT_CYCLES + 1);
  // assertion delays
  localparam int FastEnd = FAST_CYCLES - 7;
  localparam int OvEnd   = OVERSHOOT_CYCLES;
  localparam int SetEnd  = FAST_CYCLES + 1;

  logic [CTL_W-1:0]  ctl_ff [SIDES];      // control registers
  logic [FLAG_W-1:0] flag_ff;             // flag register
  logic [FLAG_W-1:0] nxt_flag;            // flag next value
  logic [SIDES-1:0]  dead_ff;             // flags disabled after clear
  logic [SIDES-1:0]  ctlWr;               // control write strobes
  logic [SIDES-1:0]  settleDone;          // settle counter expiry
  logic [SIDES-1:0]  settling;            // settle counter running
  logic [SIDES-1:0]  supEv;               // supervisor events
  logic [SIDES-1:0]  monEv;               // monitor events
  supState_t         supSt_ff [SIDES];    // registered supervisor states
  supState_t         monSt_ff [SIDES];    // registered monitor states
  logic [CW-1:0]     maskCnt_ff;          // execution mask counter
  logic [CW-1:0]     ovCnt_ff;            // overshoot window counter
  logic [CW-1:0]     entryCnt_ff;         // entry window counter
  logic              prevDeep_ff;         // deep mode last cycle
  logic [1:0]        prevLevel_ff;        // core level last cycle
  logic              stuck_ff;            // wake lost
  logic              por_ff;              // reset request
  logic [DATA_W-1:0] rdata_ff;            // read data
  logic              deep;
  logic              deep34;
  logic              flagWr;
  logic              lowFast;
  logic              highAff;
  logic              affected;
  logic              wakeTry;
  logic              loseWake;
  logic              slowWake;
  logic              maskLoad;
  logic              raiseTrip;

  assign ctlWr[LOW]  = regReq.wr && (regReq.addr == LOW_CTL_ADDR);
  assign ctlWr[HIGH] = regReq.wr && (regReq.addr == HIGH_CTL_ADDR);
  assign flagWr      = regReq.wr && (regReq.addr == FLAG_ADDR);
  assign supEv       = {highSupEvent, lowSupEvent};
  assign monEv       = {highMonEvent, lowMonEvent};
  assign deep   = (powerMode == PM_TWO) || (powerMode == PM_THREE) || (powerMode == PM_FOUR);
  assign deep34 = (powerMode == PM_THREE) || (powerMode == PM_FOUR);

  // supervisor state from control bits and mode
  function automatic supState_t supSel(input logic [CTL_W-1:0] c, input logic dp);
    if (!c[SUP_EN_BIT]) begin
      return SUP_OFF;
    end else if (!dp || (c[SUP_KEEP_BIT] && !c[AUTO_BIT])) begin
      return c[SUP_FP_BIT] ? SUP_FULL : SUP_NORMAL;
    end else if (!c[SUP_KEEP_BIT]) begin
      return SUP_OFF;
    end
    return c[SUP_FP_BIT] ? SUP_NORMAL : SUP_OFF;
  endfunction

  // monitor state has no keep bit
  function automatic supState_t monSel(input logic [CTL_W-1:0] c, input logic dp);
    if (!c[MON_EN_BIT]) begin
      return SUP_OFF;
    end else if (!dp || !c[AUTO_BIT]) begin
      return c[MON_FP_BIT] ? SUP_FULL : SUP_NORMAL;
    end
    return c[MON_FP_BIT] ? SUP_NORMAL : SUP_OFF;
  endfunction

  // control registers, one per side
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SIDES; i++) ctl_ff[i] <= CTL_RESET;
    end else begin
      for (int i = 0; i < SIDES; i++) begin
        if (ctlWr[i]) ctl_ff[i] <= regReq.wdata[CTL_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SIDES; i++) begin
        supSt_ff[i] <= SUP_OFF;
        monSt_ff[i] <= SUP_OFF;
      end
    end else begin
      for (int i = 0; i < SIDES; i++) begin
        supSt_ff[i] <= supSel(ctl_ff[i], deep);
        monSt_ff[i] <= monSel(ctl_ff[i], deep);
      end
    end
  end
  assign lowSupState  = supSt_ff[LOW];
  assign lowMonState  = monSt_ff[LOW];
  assign highSupState = supSt_ff[HIGH];
  assign highMonState = monSt_ff[HIGH];

  // settle counters, restarted by every control write
  for (genvar i = 0; i < SIDES; i++) begin : g_settle
    logic [CW-1:0] cnt_ff;
    // short delay only for full performance
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt_ff <= '0;
      end else if (ctlWr[i]) begin
        cnt_ff <= regReq.wdata[SUP_FP_BIT] ? CW'(FAST_CYCLES) : CW'(SLOW_CYCLES);
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
    assign settleDone[i] = (cnt_ff == CW'(1)) && !ctlWr[i];
    assign settling[i]   = cnt_ff != '0;
  end

  // a clear with the supervisor off disables its flags
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dead_ff <= '0;
    end else begin
      for (int i = 0; i < SIDES; i++) begin
        if (powerUpClear) dead_ff[i] <= !ctl_ff[i][SUP_EN_BIT];
        else if (ctlWr[i]) dead_ff[i] <= 1'b0;
      end
    end
  end

  // flags: written zero clears, hardware set wins
  always_comb begin
    nxt_flag = flag_ff;
    if (flagWr) nxt_flag = nxt_flag & regReq.wdata[FLAG_W-1:0];
    // a new configuration is unsettled until its counter runs out
    if (ctlWr[LOW]) nxt_flag[LOW_DLY_BIT] = 1'b0;
    if (ctlWr[HIGH]) nxt_flag[HIGH_DLY_BIT] = 1'b0;
    nxt_flag[LOW_DLY_BIT]  = nxt_flag[LOW_DLY_BIT] | settleDone[LOW];
    nxt_flag[HIGH_DLY_BIT] = nxt_flag[HIGH_DLY_BIT] | settleDone[HIGH];
    nxt_flag[LOW_SUP_BIT]  = nxt_flag[LOW_SUP_BIT] | (supEv[LOW] & ~dead_ff[LOW]);
    nxt_flag[HIGH_SUP_BIT] = nxt_flag[HIGH_SUP_BIT] | (supEv[HIGH] & ~dead_ff[HIGH]);
    nxt_flag[LOW_MON_BIT]  = nxt_flag[LOW_MON_BIT] | (monEv[LOW] & ~dead_ff[LOW]);
    nxt_flag[HIGH_MON_BIT] = nxt_flag[HIGH_MON_BIT] | (monEv[HIGH] & ~dead_ff[HIGH]);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) flag_ff <= FLAG_RESET;
    else flag_ff <= nxt_flag;
  end

  // raising the level with a 2us settle trips a reset
  assign raiseTrip = (coreLevel > prevLevel_ff) && ctl_ff[LOW][SUP_EN_BIT]
                     && ctl_ff[LOW][SUP_FP_BIT];

  // reset request from events or level raise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      por_ff       <= 1'b0;
      prevLevel_ff <= 2'h0;
    end else begin
      por_ff <= raiseTrip || (supEv[LOW] && ctl_ff[LOW][POR_EN_BIT])
                || (supEv[HIGH] && ctl_ff[HIGH][POR_EN_BIT]);
      prevLevel_ff <= coreLevel;
    end
  end
  assign porRequest = por_ff;

  // configurations that can swallow an early wake
  assign lowFast = !ctl_ff[LOW][SUP_EN_BIT] || ctl_ff[LOW][SUP_FP_BIT]
                   || !ctl_ff[LOW][MON_EN_BIT] || ctl_ff[LOW][MON_FP_BIT];
  assign highAff = (ctl_ff[HIGH][SUP_EN_BIT] && !ctl_ff[HIGH][SUP_FP_BIT]
                    && (!ctl_ff[HIGH][SUP_KEEP_BIT] || ctl_ff[HIGH][AUTO_BIT]))
                   || (ctl_ff[HIGH][MON_EN_BIT] && !ctl_ff[HIGH][MON_FP_BIT]
                    && ctl_ff[HIGH][AUTO_BIT]);
  // entering before the delay flags set is also affected
  assign affected = (lowFast && highAff) || (|settling);

  // early interrupt in affected setup is lost
  assign wakeTry   = deep && wakeIrq && !stuck_ff;
  assign loseWake  = wakeTry && (entryCnt_ff != '0) && affected;
  assign wakeGrant = wakeTry && !loseWake;

  // entry window counter restarts on each deep entry
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prevDeep_ff <= 1'b0;
      entryCnt_ff <= '0;
    end else begin
      prevDeep_ff <= deep;
      if (deep && !prevDeep_ff) entryCnt_ff <= CW'(ENTRY_CYCLES);
      else if (entryCnt_ff != '0) entryCnt_ff <= entryCnt_ff - 1'b1;
    end
  end

  // recovery wins over a new loss in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) stuck_ff <= 1'b0;
    else if (powerUpClear || extRecover) stuck_ff <= 1'b0;
    else if (loseWake) stuck_ff <= 1'b1;
  end
  assign wakeStuck = stuck_ff;

  // slow wake whenever a low side unit runs normal
  assign slowWake = (ctl_ff[LOW][SUP_EN_BIT] && !ctl_ff[LOW][SUP_FP_BIT])
                    || (ctl_ff[LOW][MON_EN_BIT] && !ctl_ff[LOW][MON_FP_BIT]);
  assign maskLoad = wakeGrant && deep34;

  // mask counter loaded on wake, holds the processor
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) maskCnt_ff <= '0;
    else if (maskLoad) maskCnt_ff <= slowWake ? CW'(SLOW_CYCLES) : CW'(FAST_CYCLES);
    else if (maskCnt_ff != '0) maskCnt_ff <= maskCnt_ff - 1'b1;
  end
  assign cpuHold = maskCnt_ff != '0;

  // overshoot window, deliberately not gated by the mask
  // so subsystem clock users still see the fast oscillator
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ovCnt_ff <= '0;
    else if (maskLoad) ovCnt_ff <= CW'(OVERSHOOT_CYCLES);
    else if (ovCnt_ff != '0) ovCnt_ff <= ovCnt_ff - 1'b1;
  end
  assign oscOvershoot = ovCnt_ff != '0;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= '0;
    end else if (!regReq.rd) begin
      rdata_ff <= '0;
    end else begin
      unique case (regReq.addr)
        LOW_CTL_ADDR:  rdata_ff <= DATA_W'(ctl_ff[LOW]);
        HIGH_CTL_ADDR: rdata_ff <= DATA_W'(ctl_ff[HIGH]);
        FLAG_ADDR:     rdata_ff <= DATA_W'(flag_ff);
        STAT_ADDR:     rdata_ff <= DATA_W'({stuck_ff, cpuHold, monSt_ff[HIGH],
                                            supSt_ff[HIGH], monSt_ff[LOW], supSt_ff[LOW]});
        default:       rdata_ff <= '0;  // unmapped reads zero
      endcase
    end
  end
  assign regRdata = rdata_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_fastMask;
    cpuHold [*8] ##FastEnd !cpuHold;
  endsequence

  chk_dead_flag_hold: assert property (dead_ff[LOW] && !ctlWr[LOW] && !powerUpClear
    |=> !$rose(flag_ff[LOW_SUP_BIT])) else $error("dead low flag was set");
  chk_slow_mask_hold: assert property (maskLoad && slowWake |=> cpuHold [*8])
    else $error("slow wake mask too short");
  chk_fast_mask_len: assert property (maskLoad && !slowWake |=> s_fastMask)
    else $error("fast wake mask length wrong");
  chk_overshoot_len: assert property (maskLoad |=> oscOvershoot ##OvEnd !oscOvershoot)
    else $error("overshoot window length wrong");
  chk_fast_settle: assert property (ctlWr[LOW] && regReq.wdata[SUP_FP_BIT]
    |-> ##SetEnd flag_ff[LOW_DLY_BIT]) else $error("fast settle flag late");
  chk_raise_reset: assert property (raiseTrip |=> porRequest)
    else $error("level raise did not reset");
  chk_lost_wake: assert property (wakeTry && entryCnt_ff != '0 && affected
    |-> !wakeGrant ##1 wakeStuck) else $error("early wake not lost");
  chk_stuck_recover: assert property (wakeStuck && (powerUpClear || extRecover)
    |=> !wakeStuck) else $error("stuck wake not recovered");
  chk_lowsup_deep_off: assert property (deep && ctl_ff[LOW][SUP_EN_BIT]
    && !ctl_ff[LOW][SUP_KEEP_BIT] |=> lowSupState == SUP_OFF) else $error("low sup not off");
  chk_mon_auto_map: assert property (deep && ctl_ff[HIGH][MON_EN_BIT]
    && ctl_ff[HIGH][AUTO_BIT] |=> highMonState == (ctl_ff[HIGH][MON_FP_BIT]
    ? SUP_NORMAL : SUP_OFF)) else $error("monitor auto state wrong");
  chk_flag_set_wins: assert property (settleDone[LOW] |=> flag_ff[LOW_DLY_BIT])
    else $error("delay flag set lost");
  chk_event_reset: assert property (lowSupEvent && ctl_ff[LOW][POR_EN_BIT] |=> porRequest)
    else $error("event did not request reset");
  chk_mask_count: assert property (cpuHold && !maskLoad
    |=> maskCnt_ff == $past(maskCnt_ff) - 1'b1) else $error("mask counter stalled");

endmodule

/* verilog/supply_supervisor_pkg.sv */
/*
  shared constants and types of the supply supervisor mode control:
  register offsets, field positions, reset values, timing figures and states.
  assumes a 40 MHz core clock and a 16-bit register port.
*/
package supply_supervisor_pkg;

  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int SIDES  = 2;              // side 0 low, side 1 high
  localparam int LOW    = 0;
  localparam int HIGH   = 1;

  // register offsets
  localparam logic [ADDR_W-1:0] LOW_CTL_ADDR  = 4'h0;
  localparam logic [ADDR_W-1:0] HIGH_CTL_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] FLAG_ADDR     = 4'h8;
  localparam logic [ADDR_W-1:0] STAT_ADDR     = 4'hC;

  // control register fields (same layout on both sides)
  localparam int CTL_W        = 7;
  localparam int SUP_EN_BIT   = 0;
  localparam int SUP_KEEP_BIT = 1;
  localparam int SUP_FP_BIT   = 2;
  localparam int MON_EN_BIT   = 3;
  localparam int MON_FP_BIT   = 4;
  localparam int AUTO_BIT     = 5;
  localparam int POR_EN_BIT   = 6;
  // enabled, normal, kept in low power, reset on event
  localparam logic [CTL_W-1:0] CTL_RESET = 7'h4B;

  // flag register fields
  localparam int FLAG_W       = 6;
  localparam int LOW_DLY_BIT  = 0;
  localparam int HIGH_DLY_BIT = 1;
  localparam int LOW_SUP_BIT  = 2;
  localparam int HIGH_SUP_BIT = 3;
  localparam int LOW_MON_BIT  = 4;
  localparam int HIGH_MON_BIT = 5;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 6'h03;

  // status register fields
  localparam int STATE_W        = 2;
  localparam int STAT_HOLD_BIT  = 8;
  localparam int STAT_STUCK_BIT = 9;

  // timing figures in microseconds and their cycle counts
  localparam int CLK_MHZ          = 40;
  localparam int SLOW_DELAY_US    = 150;
  localparam int FAST_DELAY_US    = 2;
  localparam int OVERSHOOT_US     = 6;
  localparam int ENTRY_WINDOW_US  = 1;
  localparam int FAST_CYCLES      = FAST_DELAY_US * CLK_MHZ;
  localparam int OVERSHOOT_CYCLES = OVERSHOOT_US * CLK_MHZ;
  localparam int ENTRY_CYCLES     = ENTRY_WINDOW_US * CLK_MHZ;

  // supervisor or monitor operating state
  typedef enum logic [1:0] {SUP_OFF, SUP_NORMAL, SUP_FULL} supState_t;

  // power mode reported by the core
  typedef enum logic [2:0] {PM_ACTIVE, PM_LIGHT, PM_TWO, PM_THREE, PM_FOUR} powerMode_t;

  // one register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } regReq_t;

endpackage
